// ===== rtcam_top.sv
// Clock/calendar register map with power-fail access gating.
// Assumes pins arrive asynchronously and a 40 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
`include "rtcam_cfg.svh"

module rtcam_top
   import rtcam_pkg::*;
#(
   parameter int REC_OSC_EDGES = `RTCAM_REC_EDGES
)
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   input  wire logic [7:0] ad_in,
   output var  logic [7:0] ad_out,
   output var  logic       ad_oe_out,
   input  wire logic       ale_in,
   input  wire logic       cs_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic       power_good_in,
   input  wire logic       oscillator_input_in,
   output var  logic       crystal_12p5_out
);

   ////////////////////////////////////////////////////////////////////
   // Functions

   // Writable bits of a map byte
   function automatic logic [7:0] rtcam_wmask(input logic [3:0] idx);
      logic [7:0] m;
      m = `RTCAM_WMASK_RW;
      if (idx == `RTCAM_SEC)
         m = `RTCAM_WMASK_SEC;
      else if (idx == `RTCAM_CTL_A)
         m = `RTCAM_WMASK_A;
      else if (idx == `RTCAM_FLAGS || idx == `RTCAM_VALID)
         m = `RTCAM_WMASK_RO;
      return m;
   endfunction

   // Count up with wrap, binary or BCD; bit 8 flags the wrap
   function automatic logic [8:0] rtcam_inc(input logic [7:0] v,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi,
                                            input logic       bcd);
      logic [8:0] r;
      r = {1'b0, v + 8'h01};
      if (v >= hi)
         r = {1'b1, lo};
      else if (bcd && v[3:0] == 4'h9)
         r = {1'b0, v + 8'h07};
      return r;
   endfunction

   // Alarm byte match with don't-care code
   function automatic logic rtcam_match(input logic [7:0] alarm,
                                        input logic [7:0] cnt);
      return (alarm[7:6] == 2'b11) || (alarm == cnt);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two stages plus edge history
   logic [13:0] sy1_reg;
   logic [13:0] sy2_reg;
   logic [13:0] prev_reg;

   // Pins pass two flops before any use
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sy1_reg  <= `RTCAM_SYNC_RST;
         sy2_reg  <= `RTCAM_SYNC_RST;
         prev_reg <= `RTCAM_SYNC_RST;
      end
      else
      begin
         sy1_reg  <= {ad_in, ale_in, cs_n_in, rd_n_in, wr_n_in,
                      power_good_in, oscillator_input_in};
         sy2_reg  <= sy1_reg;
         prev_reg <= sy2_reg;
      end
   end

   logic [7:0] ad_s;
   logic       cs_act;
   logic       rd_act;
   logic       pg_s;
   logic       ale_fall;
   logic       wr_rise;
   logic       rd_rise;
   logic       osc_rise;

   // Decoded pin levels and edges
   assign ad_s     = sy2_reg[13:6];
   assign cs_act   = ~sy2_reg[4];
   assign rd_act   = ~sy2_reg[3];
   assign pg_s     = sy2_reg[1];
   assign ale_fall = prev_reg[5] & ~sy2_reg[5];
   assign rd_rise  = ~prev_reg[3] & sy2_reg[3];
   assign wr_rise  = ~prev_reg[2] & sy2_reg[2];
   assign osc_rise = ~prev_reg[0] & sy2_reg[0];

   ////////////////////////////////////////////////////////////////////
   // Access gating
   rtcam_gate_t gate_reg;
   rtcam_gate_t gate_next;
   logic [12:0] rec_cnt_reg;
   logic [12:0] rec_cnt_next;
   logic [11:0] osc_wd_reg;
   logic [11:0] osc_wd_next;
   logic [7:0]  ctl_a;
   logic        div_hold;
   logic        osc_running;
   logic        access_ok;

   assign div_hold    = (ctl_a[6:5] == `RTCAM_DV_HOLD);
   assign osc_running = (osc_wd_reg != 12'h000);
   assign access_ok   = (gate_reg == RTCAM_READY) && pg_s &&
                        osc_running && !div_hold;

   // Power-fail, recovery delay and oscillator watchdog
   always_comb
   begin
      gate_next    = gate_reg;
      rec_cnt_next = rec_cnt_reg;
      osc_wd_next  = osc_wd_reg;
      if (osc_rise)
         osc_wd_next = 12'(`RTCAM_OSC_LOST_CYC);
      else if (osc_wd_reg != 12'h000)
         osc_wd_next = osc_wd_reg - 12'h001;
      unique case (gate_reg)
         RTCAM_PFAIL:
         begin
            rec_cnt_next = 13'h0000;
            if (pg_s)
               gate_next = RTCAM_RECOVER;
         end
         RTCAM_RECOVER:
         begin
            if (!pg_s)
               gate_next = RTCAM_PFAIL;
            else if (rec_cnt_reg == 13'(REC_OSC_EDGES - 1) && osc_rise)
               gate_next = RTCAM_READY;
            else if (osc_rise)
               rec_cnt_next = rec_cnt_reg + 13'h0001;
         end
         RTCAM_READY:
         begin
            if (!pg_s)
               gate_next = RTCAM_PFAIL;
         end
         default:
            gate_next = RTCAM_PFAIL;
      endcase
   end

   // Gating state registers
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         gate_reg    <= RTCAM_PFAIL;
         rec_cnt_reg <= 13'h0000;
         osc_wd_reg  <= 12'h000;
      end
      else
      begin
         gate_reg    <= gate_next;
         rec_cnt_reg <= rec_cnt_next;
         osc_wd_reg  <= osc_wd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register map, timekeeping and host bus
   logic [7:0]  map_reg [0:13];
   logic [7:0]  map_next [0:13];
   logic [7:0]  ext_reg;
   logic [7:0]  ext_next;
   logic [14:0] pre_reg;
   logic [14:0] pre_next;
   logic [7:0]  addr_reg;
   logic [7:0]  addr_next;
   logic [7:0]  ad_out_reg;
   logic [7:0]  ad_out_next;
   logic        ad_oe_reg;
   logic        ad_oe_next;
   logic        bcd;
   logic        hit_map;
   logic        hit_ext;
   logic        uip;
   logic [7:0]  flags_rd;
   logic [7:0]  rd_data;

   assign ctl_a   = map_reg[`RTCAM_CTL_A];
   assign bcd     = map_reg[`RTCAM_CTL_B][`RTCAM_B_BCD_N];
   assign hit_map = (addr_reg < `RTCAM_MAP_BYTES);
   assign hit_ext = (addr_reg == `RTCAM_EXT_ADDR);
   assign uip     = (pre_reg >= `RTCAM_UIP_START) && !div_hold;
   assign flags_rd = {map_reg[`RTCAM_FLAGS][6:0] != 7'h00,
                      map_reg[`RTCAM_FLAGS][6:0]};

   // Read data; read-only bits come from internal state
   always_comb
   begin
      rd_data = 8'h00;
      if (hit_ext)
         rd_data = ext_reg;
      else if (hit_map)
      begin
         unique case (addr_reg[3:0])
            `RTCAM_SEC:   rd_data = {1'b0, map_reg[`RTCAM_SEC][6:0]};
            `RTCAM_CTL_A: rd_data = {uip, ctl_a[6:0]};
            `RTCAM_FLAGS: rd_data = flags_rd;
            `RTCAM_VALID: rd_data = `RTCAM_VALID_VAL;
            default:      rd_data = map_reg[addr_reg[3:0]];
         endcase
      end
   end

   // Next state of map, prescaler, address latch and bus drive
   always_comb
   begin
      logic [8:0] s;
      logic [8:0] m;
      logic [8:0] h;
      logic [8:0] w;
      logic [8:0] d;
      logic [8:0] mo;
      logic [8:0] y;
      logic       tick;
      s  = 9'h000;
      m  = 9'h000;
      h  = 9'h000;
      w  = 9'h000;
      d  = 9'h000;
      mo = 9'h000;
      y  = 9'h000;
      tick = 1'b0;
      for (int i = 0; i < 14; i++)
         map_next[i] = map_reg[i];
      ext_next  = ext_reg;
      addr_next = addr_reg;
      // Prescaler runs on the oscillator, held by divider control
      tick = osc_rise && !div_hold && (pre_reg == `RTCAM_PRE_LAST);
      if (div_hold)
         pre_next = 15'h0000;
      else if (osc_rise)
         pre_next = pre_reg + 15'h0001;
      else
         pre_next = pre_reg;
      // Once-a-second advance, independent of host gating
      if (tick && !map_reg[`RTCAM_CTL_B][`RTCAM_B_SET])
      begin
         s = rtcam_inc(map_reg[`RTCAM_SEC], 8'h00,
                       bcd ? `RTCAM_SEC_HI_BCD : `RTCAM_SEC_HI_BIN, bcd);
         m = rtcam_inc(map_reg[`RTCAM_MIN], 8'h00,
                       bcd ? `RTCAM_SEC_HI_BCD : `RTCAM_SEC_HI_BIN, bcd);
         h = rtcam_inc(map_reg[`RTCAM_HOUR], 8'h00,
                       bcd ? `RTCAM_HR_HI_BCD : `RTCAM_HR_HI_BIN, bcd);
         w = rtcam_inc(map_reg[`RTCAM_WDAY], 8'h01, `RTCAM_WDAY_HI, bcd);
         d = rtcam_inc(map_reg[`RTCAM_MDAY], 8'h01,
                       bcd ? `RTCAM_MDAY_HI_BCD : `RTCAM_MDAY_HI_BIN, bcd);
         mo = rtcam_inc(map_reg[`RTCAM_MONTH], 8'h01,
                        bcd ? `RTCAM_MON_HI_BCD : `RTCAM_MON_HI_BIN, bcd);
         y = rtcam_inc(map_reg[`RTCAM_YEAR], 8'h00,
                       bcd ? `RTCAM_YEAR_HI_BCD : `RTCAM_YEAR_HI_BIN, bcd);
         map_next[`RTCAM_SEC] = s[7:0];
         if (s[8])
            map_next[`RTCAM_MIN] = m[7:0];
         if (s[8] && m[8])
         begin
            map_next[`RTCAM_HOUR] = h[7:0];
            if (h[8])
            begin
               map_next[`RTCAM_WDAY] = w[7:0];
               map_next[`RTCAM_MDAY] = d[7:0];
               if (d[8])
                  map_next[`RTCAM_MONTH] = mo[7:0];
               if (d[8] && mo[8])
                  map_next[`RTCAM_YEAR] = y[7:0];
            end
         end
         map_next[`RTCAM_FLAGS][`RTCAM_C_UF] = 1'b1;
         if (rtcam_match(map_reg[`RTCAM_SEC_MATCH], map_next[`RTCAM_SEC]) &&
             rtcam_match(map_reg[`RTCAM_MIN_MATCH], map_next[`RTCAM_MIN]) &&
             rtcam_match(map_reg[`RTCAM_HOUR_MATCH], map_next[`RTCAM_HOUR]))
            map_next[`RTCAM_FLAGS][`RTCAM_C_AF] = 1'b1;
      end
      // Select may rise with the read strobe, so use its held level
      else if (rd_rise && !prev_reg[4] && access_ok && hit_map &&
               addr_reg[3:0] == `RTCAM_FLAGS)
         map_next[`RTCAM_FLAGS] = 8'h00;   // Read clears, set wins
      // Address latch on falling strobe, even without select
      if (ale_fall && pg_s)
         addr_next = ad_s;
      // Gated write at end of write pulse
      if (wr_rise && cs_act && access_ok)
      begin
         if (hit_map)
            map_next[addr_reg[3:0]] =
               (map_reg[addr_reg[3:0]] & ~rtcam_wmask(addr_reg[3:0])) |
               (ad_s & rtcam_wmask(addr_reg[3:0]));
         else if (hit_ext)
            ext_next = ad_s;
      end
      // Drive only during a selected, permitted read
      ad_oe_next  = rd_act && cs_act && access_ok && (hit_map || hit_ext);
      ad_out_next = ad_oe_next ? rd_data : 8'h00;
   end

   // Map, prescaler and bus registers
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < 14; i++)
            map_reg[i] <= 8'h00;
         map_reg[`RTCAM_CTL_A] <= `RTCAM_A_RST;
         ext_reg    <= 8'h00;
         pre_reg    <= 15'h0000;
         addr_reg   <= 8'h00;
         ad_out_reg <= 8'h00;
         ad_oe_reg  <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < 14; i++)
            map_reg[i] <= map_next[i];
         ext_reg    <= ext_next;
         pre_reg    <= pre_next;
         addr_reg   <= addr_next;
         ad_out_reg <= ad_out_next;
         ad_oe_reg  <= ad_oe_next;
      end
   end

   // Outputs straight from flops
   assign ad_out           = ad_out_reg;
   assign ad_oe_out        = ad_oe_reg;
   assign crystal_12p5_out = ext_reg[`RTCAM_EXT_XSEL];

endmodule // rtcam_top

`default_nettype wire

// ===== rtcam_cfg.svh
// Constants of the clock/calendar access and map block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef RTCAM_CFG_SVH
`define RTCAM_CFG_SVH

// Clock rates and time figures
`define RTCAM_CLK_HZ        40000000
`define RTCAM_OSC_HZ        32768
`define RTCAM_REC_TIME_MS   200
`define RTCAM_REC_EDGES     ((`RTCAM_REC_TIME_MS * `RTCAM_OSC_HZ) / 1000)
`define RTCAM_OSC_LOST_CYC  ((`RTCAM_CLK_HZ / `RTCAM_OSC_HZ) * 3)
`define RTCAM_PRE_LAST      15'h7fff
`define RTCAM_UIP_START     15'h7ff8

// Register map
`define RTCAM_MAP_BYTES     8'h0e
`define RTCAM_SEC           4'h0
`define RTCAM_SEC_MATCH     4'h1
`define RTCAM_MIN           4'h2
`define RTCAM_MIN_MATCH     4'h3
`define RTCAM_HOUR          4'h4
`define RTCAM_HOUR_MATCH    4'h5
`define RTCAM_WDAY          4'h6
`define RTCAM_MDAY          4'h7
`define RTCAM_MONTH         4'h8
`define RTCAM_YEAR          4'h9
`define RTCAM_CTL_A         4'ha
`define RTCAM_CTL_B         4'hb
`define RTCAM_FLAGS         4'hc
`define RTCAM_VALID         4'hd
`define RTCAM_EXT_ADDR      8'h4b

// Field positions and writable masks
`define RTCAM_WMASK_SEC     8'h7f
`define RTCAM_WMASK_A       8'h7f
`define RTCAM_WMASK_RO      8'h00
`define RTCAM_WMASK_RW      8'hff
`define RTCAM_B_SET         7
`define RTCAM_B_AIE         5
`define RTCAM_B_UIE         4
`define RTCAM_B_BCD_N       2
`define RTCAM_C_IRQF        7
`define RTCAM_C_AF          5
`define RTCAM_C_UF          4
`define RTCAM_EXT_XSEL      3
`define RTCAM_DV_HOLD       2'b11

// Reset values
`define RTCAM_A_RST         8'h20
`define RTCAM_VALID_VAL     8'h80
`define RTCAM_SYNC_RST      14'h001c

// Counting limits, binary and BCD
`define RTCAM_SEC_HI_BIN    8'h3b
`define RTCAM_SEC_HI_BCD    8'h59
`define RTCAM_HR_HI_BIN     8'h17
`define RTCAM_HR_HI_BCD     8'h23
`define RTCAM_WDAY_HI       8'h07
`define RTCAM_MDAY_HI_BIN   8'h1f
`define RTCAM_MDAY_HI_BCD   8'h31
`define RTCAM_MON_HI_BIN    8'h0c
`define RTCAM_MON_HI_BCD    8'h12
`define RTCAM_YEAR_HI_BIN   8'h63
`define RTCAM_YEAR_HI_BCD   8'h99

`endif

// ===== rtcam_pkg.sv
// Types of the clock/calendar access and map block.
// Assumes rtcam_cfg.svh is on the include path.
`default_nettype none
`include "rtcam_cfg.svh"

package rtcam_pkg;

   // Host access gating states
   typedef enum logic [1:0]
   {
      RTCAM_PFAIL   = 2'b00,
      RTCAM_RECOVER = 2'b01,
      RTCAM_READY   = 2'b10
   } rtcam_gate_t;

endpackage

`default_nettype wire

// ===== rtcam_access_monitor.sv
// Checker of host access gating on the top-level pins.
// Assumes it is bound to rtcam_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module rtcam_access_monitor #(
   parameter int REC_OSC_EDGES = 4
)
(
   input wire logic       sys_clk_in,
   input wire logic       rst_in,
   input wire logic [7:0] ad_out,
   input wire logic       ad_oe_out,
   input wire logic       cs_n_in,
   input wire logic       rd_n_in,
   input wire logic       wr_n_in,
   input wire logic       power_good_in,
   input wire logic       crystal_12p5_out
);
   logic       wr_n_reg;
   logic       wr_n_next;
   logic [3:0] age_reg;
   logic [3:0] age_next;

   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   ////////////////////////////////////////
   // Cycles since the write strobe rose
   always_comb
   begin
      wr_n_next = wr_n_in;
      age_next  = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
      if (wr_n_in && !wr_n_reg)
         age_next = 4'h0;
   end

   // Registers of the strobe age
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_n_reg <= 1'b1;
         age_reg  <= 4'hf;
      end
      else
      begin
         wr_n_reg <= wr_n_next;
         age_reg  <= age_next;
      end
   end

   ////////////////////////////////////////
   // Bus behaviour
   AST_PF_QUIET: assert property (!power_good_in [*6] |-> !ad_oe_out)
      else $error("Bus driven during power fail");
   AST_PG_FALL: assert property ($fell(power_good_in) |-> ##[1:6] !ad_oe_out)
      else $error("Bus not released after power fail");
   AST_RECOVER: assert property ($rose(power_good_in) |-> !ad_oe_out [*8])
      else $error("Bus driven inside recovery");
   AST_CS_QUIET: assert property (cs_n_in [*6] |-> !ad_oe_out)
      else $error("Bus driven without chip select");
   AST_OE_CAUSE: assert property ($rose(ad_oe_out) |->
         !$past(rd_n_in, 2) && !$past(cs_n_in, 2) && $past(power_good_in, 2))
      else $error("Bus driven without a read cycle");
   AST_RD_END: assert property ($rose(rd_n_in) |-> ##[1:6] !ad_oe_out)
      else $error("Bus held after read ended");
   AST_OUT_ZERO: assert property (!ad_oe_out |-> ad_out == 8'h00)
      else $error("Data out not idle");
   AST_XTAL_WR: assert property ($changed(crystal_12p5_out) |->
         age_reg <= 4'h8 && power_good_in)
      else $error("Crystal select moved without a write");
   AST_RD_QUIET: assert property (rd_n_in [*6] |-> !ad_oe_out)
      else $error("Bus driven without read strobe");
endmodule // rtcam_access_monitor

bind rtcam_top rtcam_access_monitor #(.REC_OSC_EDGES(REC_OSC_EDGES))
   u_rtcam_access_monitor (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ad_out(ad_out),
   .ad_oe_out(ad_oe_out), .cs_n_in(cs_n_in), .rd_n_in(rd_n_in),
   .wr_n_in(wr_n_in), .power_good_in(power_good_in),
   .crystal_12p5_out(crystal_12p5_out));
`default_nettype wire

// ===== rtcam_host_model.sv
// Host processor model on the multiplexed address/data pins.
// Assumes the system clock; pins change just after falling edges.
`timescale 1ns/100ps
`default_nettype none
module rtcam_host_model
(
   input  wire logic       clk_in,
   input  wire logic [7:0] ad_dev_in,
   input  wire logic       ad_oe_in,
   output var  logic [7:0] ad_out,
   output var  logic       ale_out,
   output var  logic       cs_n_out,
   output var  logic       rd_n_out,
   output var  logic       wr_n_out
);
   logic [7:0] drv_reg = 8'h00;
   logic       oe_reg  = 1'b0;

   ////////////////////////////////////////
   // Wire level: device, else host, else inverse of last value
   always_comb
      ad_out = ad_oe_in ? ad_dev_in : (oe_reg ? drv_reg : ~drv_reg);

   // Idle strobes
   initial
      {ale_out, cs_n_out, rd_n_out, wr_n_out} = 4'h7;

   // Address phase, latched on strobe fall
   task automatic addr_phase(input logic [7:0] addr);
      @(negedge clk_in);
      drv_reg = addr;
      oe_reg = 1'b1;
      ale_out = 1'b1;
      repeat (4) @(negedge clk_in);
      ale_out = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask

   // Write cycle; data held past the strobe rise
   task automatic bus_write(input logic [7:0] addr, input logic [7:0] data,
                            input logic sel);
      addr_phase(addr);
      drv_reg = data;
      cs_n_out = ~sel;
      wr_n_out = 1'b0;
      repeat (6) @(negedge clk_in);
      wr_n_out = 1'b1;
      repeat (4) @(negedge clk_in);
      cs_n_out = 1'b1;
      oe_reg = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask

   // Read cycle; bus released before the strobe
   task automatic bus_read(input logic [7:0] addr);
      addr_phase(addr);
      oe_reg = 1'b0;
      cs_n_out = 1'b0;
      rd_n_out = 1'b0;
      repeat (8) @(negedge clk_in);
      rd_n_out = 1'b1;
      cs_n_out = 1'b1;
      repeat (8) @(negedge clk_in);
   endtask
endmodule // rtcam_host_model
`default_nettype wire

// ===== test_rtcam_top.sv
// Self-checking bench of clock/calendar access gating and map.
// Assumes the host model and the checker compile first.
`timescale 1ns/100ps
`default_nettype none
module test_rtcam_top;
   logic       sys_clk_in    = 1'b0;
   logic       rst_in        = 1'b1;
   logic       power_good_in = 1'b0;
   logic       osc           = 1'b0;
   logic [7:0] ad_in;
   logic [7:0] ad_out;
   logic       ad_oe_out;
   logic       ale;
   logic       cs_n;
   logic       rd_n;
   logic       wr_n;
   logic       crystal_12p5_out;
   logic [7:0] exp_q[$];
   logic [7:0] shadow [0:15];
   logic [7:0] drives = 8'h00;
   logic       oe_q = 1'b0;
   int         num_errors = 0;
   int         tests_run = 0;
   int unsigned seed_done;

   rtcam_top #(.REC_OSC_EDGES(4)) u_rtcam_top (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ad_in(ad_in),
      .ad_out(ad_out), .ad_oe_out(ad_oe_out), .ale_in(ale),
      .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
      .power_good_in(power_good_in), .oscillator_input_in(osc),
      .crystal_12p5_out(crystal_12p5_out));

   rtcam_host_model u_host (
      .clk_in(sys_clk_in), .ad_dev_in(ad_out), .ad_oe_in(ad_oe_out),
      .ad_out(ad_in), .ale_out(ale), .cs_n_out(cs_n),
      .rd_n_out(rd_n), .wr_n_out(wr_n));

   ////////////////////////////////////////
   // Clocks: system and oscillator
   initial
      forever
         #12.5 sys_clk_in = ~sys_clk_in;
   initial
      forever
         #15259 osc = ~osc;

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Single-bit result compare
   task automatic check_bit(input string what, input logic exp,
                            input logic got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Read expecting data; the note must be taken by then
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.bus_read(a);
      check("reads_pending", 8'h00, 8'(exp_q.size()));
   endtask

   // Read expecting no drive at all
   task automatic rd_none(input logic [7:0] a);
      logic [7:0] d0;
      d0 = drives;
      u_host.bus_read(a);
      check("refused_drive", d0, drives);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host.bus_write(a, d, 1'b1);
   endtask

   task automatic recover;
      repeat (8) @(posedge osc);
      @(negedge sys_clk_in);
   endtask

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Result watcher: oldest note against each drive
   always @(negedge sys_clk_in)
   begin
      if (ad_oe_out === 1'b1 && oe_q !== 1'b1)
      begin
         drives = drives + 8'h01;
         if (exp_q.size() == 0)
            check("unexpected_drive", 8'h00, 8'h01);
         else
            check("read_data", exp_q.pop_front(), ad_out);
      end
      oe_q = ad_oe_out;
   end

   // Watchdog
   initial
   begin
      #(25.0 * 60000);
      num_errors++;
      $display("watchdog expired");
      end_of_test();
   end

   ////////////////////////////////////////
   // Main sequence
   initial
   begin
      logic [7:0] x;
      seed_done = $urandom(71);
      repeat (16) @(negedge sys_clk_in);
      rst_in = 1'b0;
      wr(8'h01, 8'h5a);
      rd_none(8'h01);
      power_good_in = 1'b1;
      rd_none(8'h01);
      recover();
      rd_exp(8'h01, 8'h00);
      rd_exp(8'h0a, 8'h20);
      rd_exp(8'h0d, 8'h80);
      $display("end of gating test");
      for (int i = 1; i < 12; i++)
         if (i != 10)
         begin
            shadow[i] = 8'($urandom);
            wr(8'(i), shadow[i]);
            rd_exp(8'(i), shadow[i]);
         end
      for (int j = 0; j < 2; j++)
      begin
         x = 8'($urandom);
         x[3] = (j == 1);
         wr(8'h4b, x);
         rd_exp(8'h4b, x);
         check_bit("crystal", x[3], crystal_12p5_out);
      end
      $display("end of read-write test");
      wr(8'h00, 8'hff);
      rd_exp(8'h00, 8'h7f);
      wr(8'h0a, 8'ha0);
      rd_exp(8'h0a, 8'h20);
      wr(8'h0c, 8'hff);
      rd_exp(8'h0c, 8'h00);
      wr(8'h0d, 8'h00);
      rd_exp(8'h0d, 8'h80);
      $display("end of read-only test");
      u_host.bus_write(8'h02, ~shadow[2], 1'b0);
      rd_exp(8'h02, shadow[2]);
      wr(8'h0e, 8'h55);
      rd_none(8'h0e);
      $display("end of select test");
      power_good_in = 1'b0;
      repeat (4) @(negedge sys_clk_in);
      wr(8'h01, ~shadow[1]);
      rd_none(8'h01);
      power_good_in = 1'b1;
      recover();
      rd_exp(8'h01, shadow[1]);
      $display("end of power fail test");
      wr(8'h0a, 8'h60);
      rd_none(8'h01);
      $display("end of divider hold test");
      end_of_test();
   end
endmodule // test_rtcam_top
`default_nettype wire
